// ==== rtl/abc_pkg.sv ====
// Package with timing constants and state encodings for the converter bus controller
package abc_pkg;
   localparam int unsigned CLK_PERIOD_NS   = 50;
   localparam int unsigned WR_PULSE_NS     = 250;
   localparam int unsigned EARLY_READ_NS   = 250;
   localparam int unsigned TIMEOUT_NS      = 380;
   localparam int unsigned RD_ACCESS_NS    = 150;
   localparam int unsigned GAP_NS          = 350;
   localparam int unsigned WAIT_LIMIT_NS   = 2000;
   localparam int unsigned WR_PULSE_CYC    = (WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned EARLY_READ_CYC  = (EARLY_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned TIMEOUT_CYC     = (TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RD_ACCESS_CYC   = (RD_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned GAP_CYC         = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned WAIT_LIMIT_CYC  = WAIT_LIMIT_NS / CLK_PERIOD_NS;
   localparam int unsigned CNT_W           = 8;
   localparam int unsigned DATA_W          = 8;
   localparam int unsigned FIFO_DEPTH      = 16;
   localparam logic        MODE_RD         = 1'b0;
   localparam logic        MODE_WR_RD      = 1'b1;
   localparam logic [7:0]  BIPOLAR_FLIP    = 8'h80;

   typedef enum logic [2:0]
   {
      ST_IDLE   = 3'b000,
      ST_WRITE  = 3'b001,
      ST_WAIT   = 3'b010,
      ST_READ   = 3'b011,
      ST_RDWAIT = 3'b100,
      ST_PUSH   = 3'b101,
      ST_GAP    = 3'b110
   } abc_state_t;
endpackage : abc_pkg

// ==== rtl/abc_stream_if.sv ====
// Interface carrying result words from the controller into the FIFO
`timescale 1ns/1ps
interface abc_stream_if #(parameter int unsigned W = 8);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport dst (input valid, input data, output ready);
endinterface : abc_stream_if

// ==== rtl/abc_fifo.sv ====
// Result FIFO with valid and ready on both sides
`timescale 1ns/1ps
module abc_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 16
)(
   // Clock and reset
   input  wire logic             clk_in,
   input  wire logic             rst_n_in,
   // Write side
   abc_stream_if.dst             wr,
   // Read side
   output logic                  rd_valid_out,
   input  wire logic             rd_ready_in,
   output logic [WIDTH-1:0]      rd_data_out
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0]      wp_q;
   logic [AW:0]      rp_q;
   logic [AW+1:0]    fill;
   logic             full;
   logic             empty;
   logic             do_wr;
   logic             do_rd;

   // Output register counts as a slot, so no more than DEPTH words are held
   assign fill         = {1'b0, wp_q - rp_q} + {{(AW+1){1'b0}}, rd_valid_out};
   assign full         = (fill >= DEPTH[AW+1:0]);
   assign empty        = (wp_q == rp_q);
   assign wr.ready     = !full;
   assign do_wr        = wr.valid && !full;
   assign do_rd        = rd_valid_out && rd_ready_in;

   always_ff @(posedge clk_in)
   begin
      if (do_wr)
         mem_q[wp_q[AW-1:0]] <= wr.data;
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         wp_q <= '0;
      else if (do_wr)
         wp_q <= wp_q + 1'b1;
   end

   // Registered read stage
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rp_q         <= '0;
         rd_valid_out <= 1'b0;
         rd_data_out  <= '0;
      end
      else if (!empty && (!rd_valid_out || do_rd))
      begin
         rd_data_out  <= mem_q[rp_q[AW-1:0]];
         rd_valid_out <= 1'b1;
         rp_q         <= rp_q + 1'b1;
      end
      else if (do_rd)
         rd_valid_out <= 1'b0;
   end
endmodule : abc_fifo

// ==== rtl/abc_ctrl.sv ====
// Bus master that drives an 8-bit sampling converter through its strobes
`timescale 1ns/1ps
// Behaviour
// - Mode pin low: start conversion by lowering select and read together.
// - Read-started mode: hold select and read low until the result appears; the code releases them after 2000 ns if it has not.
// - Master uses the wait output to stretch its read cycle.
// - Mode pin high: shared pin is start strobe; conversion starts on its rise.
// - Early read: ignore flag, lower read 250 ns after strobe rises.
// - Leave at least 350 ns between successive conversions.
module abc_ctrl
   import abc_pkg::*;
#(
   parameter int unsigned FIFO_D = FIFO_DEPTH
)(
   // Clock and reset
   input  wire logic              clk_in,
   input  wire logic              rst_n_in,
   // Control
   input  wire logic              start_in,
   input  wire logic              mode_in,
   input  wire logic              early_read_in,
   input  wire logic              bipolar_in,
   output logic                   busy_out,
   output logic                   timeout_err_out,
   // Converter pins
   output logic                   cs_n_out,
   output logic                   rd_n_out,
   output logic                   mode_out,
   input  wire logic              strobe_pin_in,
   output logic                   strobe_pin_out,
   output logic                   strobe_pin_oe_n_out,
   input  wire logic              done_n_in,
   input  wire logic [DATA_W-1:0] result_bus_in,
   // Result stream
   output logic                   res_valid_out,
   input  wire logic              res_ready_in,
   output logic [DATA_W-1:0]      res_data_out
);
   abc_state_t        state_q;
   abc_state_t        state_d;
   logic [CNT_W-1:0]  cnt_q;
   logic              cnt_clr;
   logic              mode_q;
   logic              early_q;
   logic              bip_q;
   logic [DATA_W-1:0] word_q;
   logic              err_q;
   logic              wait_low;
   logic              ready_now;

   abc_stream_if #(.W(DATA_W)) push_if ();

   // Wait line reads low only while the converter holds it; released reads high
   assign wait_low = (mode_q == MODE_RD) && !strobe_pin_in;

   // Converter is ready to be read in this cycle
   always_comb
   begin
      ready_now = 1'b0;
      if (mode_q == MODE_RD)
         ready_now = !wait_low && (cnt_q >= CNT_W'(RD_ACCESS_CYC));
      else if (early_q)
         ready_now = (cnt_q >= CNT_W'(RD_ACCESS_CYC));
      else
         ready_now = (cnt_q >= CNT_W'(RD_ACCESS_CYC)) && !done_n_in;
   end

   always_comb
   begin
      state_d = state_q;
      cnt_clr = 1'b0;
      case (state_q)
         ST_IDLE:
            if (start_in && push_if.ready)
            begin
               cnt_clr = 1'b1;
               state_d = (mode_in == MODE_RD) ? ST_RDWAIT : ST_WRITE;
            end
         ST_WRITE:
            if (cnt_q >= CNT_W'(WR_PULSE_CYC - 1))
            begin
               cnt_clr = 1'b1;
               state_d = ST_WAIT;
            end
         ST_WAIT:
            if (early_q && cnt_q >= CNT_W'(EARLY_READ_CYC - 1))
            begin
               cnt_clr = 1'b1;
               state_d = ST_READ;
            end
            else if (!early_q && !done_n_in)
            begin
               cnt_clr = 1'b1;
               state_d = ST_READ;
            end
            else if (cnt_q >= CNT_W'(WAIT_LIMIT_CYC))
            begin
               cnt_clr = 1'b1;
               state_d = ST_GAP;
            end
         ST_READ, ST_RDWAIT:
            if (ready_now)
            begin
               cnt_clr = 1'b1;
               state_d = ST_PUSH;
            end
            else if (cnt_q >= CNT_W'(WAIT_LIMIT_CYC))
            begin
               cnt_clr = 1'b1;
               state_d = ST_GAP;
            end
         ST_PUSH:
         begin
            cnt_clr = 1'b1;
            state_d = ST_GAP;
         end
         ST_GAP:
            if (cnt_q >= CNT_W'(GAP_CYC - 1))
            begin
               cnt_clr = 1'b1;
               state_d = ST_IDLE;
            end
         default:
         begin
            cnt_clr = 1'b1;
            state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         state_q <= ST_IDLE;
      else
         state_q <= state_d;
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         cnt_q <= '0;
      else if (cnt_clr)
         cnt_q <= '0;
      else if (cnt_q != '1)
         cnt_q <= cnt_q + 1'b1;
   end

   // Configuration captured at start of each conversion
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         mode_q  <= MODE_RD;
         early_q <= 1'b0;
         bip_q   <= 1'b0;
      end
      else if (state_q == ST_IDLE && start_in)
      begin
         mode_q  <= mode_in;
         early_q <= early_read_in;
         bip_q   <= bipolar_in;
      end
   end

   // Result latched; bipolar offset binary turned to two's complement
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         word_q <= '0;
      else if ((state_q == ST_READ || state_q == ST_RDWAIT) && ready_now)
         word_q <= bip_q ? (result_bus_in ^ BIPOLAR_FLIP) : result_bus_in;
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         err_q <= 1'b0;
      else if (state_q == ST_IDLE && start_in)
         err_q <= 1'b0;
      else if (state_d == ST_GAP && state_q != ST_PUSH && state_q != ST_GAP)
         err_q <= 1'b1;
   end

   // Pin drive: strobes high except in the access phases
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         cs_n_out <= 1'b1;
         rd_n_out <= 1'b1;
      end
      else
      begin
         cs_n_out <= !(state_d == ST_WRITE || state_d == ST_WAIT
                       || state_d == ST_READ || state_d == ST_RDWAIT);
         rd_n_out <= !(state_d == ST_READ || state_d == ST_RDWAIT);
      end
   end

   // Shared pin driven as start strobe only in write-started mode
   assign mode_out            = mode_q;
   assign strobe_pin_out      = (state_q != ST_WRITE);
   assign strobe_pin_oe_n_out = (mode_q == MODE_RD);

   assign push_if.valid = (state_q == ST_PUSH);
   assign push_if.data  = word_q;

   assign busy_out        = (state_q != ST_IDLE);
   assign timeout_err_out = err_q;

   abc_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(FIFO_D)
   ) u_fifo (
      .clk_in      (clk_in),
      .rst_n_in    (rst_n_in),
      .wr          (push_if),
      .rd_valid_out(res_valid_out),
      .rd_ready_in (res_ready_in),
      .rd_data_out (res_data_out)
   );
endmodule : abc_ctrl

// ==== bench/abc_ctrl_assertions.sv ====
// Checker for the converter bus controller ports
`timescale 1ns/1ps
module abc_ctrl_assertions
   import abc_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic early_read_in,
   input wire logic busy_out,
   input wire logic timeout_err_out,
   input wire logic cs_n_out,
   input wire logic rd_n_out,
   input wire logic mode_out,
   input wire logic strobe_pin_in,
   input wire logic strobe_pin_out,
   input wire logic strobe_pin_oe_n_out,
   input wire logic done_n_in
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   chk_rd_start_together: assert property ($fell(cs_n_out) && mode_out == MODE_RD |-> !rd_n_out)
      else $error("read start without read strobe");
   chk_rd_hold_wait: assert property (mode_out == MODE_RD && !cs_n_out && !rd_n_out && !strobe_pin_in
      |=> (!cs_n_out && !rd_n_out) or (1'b1 ##1 timeout_err_out))
      else $error("read released while wait low");
   chk_rd_release_after: assert property (mode_out == MODE_RD && $rose(rd_n_out)
      |-> $past(strobe_pin_in) || timeout_err_out)
      else $error("read ended before wait released");
   chk_wr_pulse_width: assert property (!strobe_pin_oe_n_out && $fell(strobe_pin_out)
      |-> (!cs_n_out && !strobe_pin_out)[*5] ##1 strobe_pin_out)
      else $error("start strobe pulse wrong");
   chk_early_read_gap: assert property (mode_out == MODE_WR_RD && $rose(strobe_pin_out)
      |-> rd_n_out[*5])
      else $error("read too soon after start strobe");
   chk_read_after_flag: assert property (mode_out == MODE_WR_RD && !early_read_in && $fell(rd_n_out)
      |-> !done_n_in)
      else $error("read before completion flag");
   chk_conv_gap: assert property ($rose(cs_n_out) |-> cs_n_out[*7])
      else $error("conversion gap too short");
   chk_pin_drive_mode: assert property (!strobe_pin_out |-> !strobe_pin_oe_n_out && !cs_n_out)
      else $error("start strobe pulsed while pin released or select high");
   chk_idle_quiet: assert property (!busy_out |-> cs_n_out && rd_n_out)
      else $error("strobes active while idle");
endmodule : abc_ctrl_assertions
bind abc_ctrl abc_ctrl_assertions abc_ctrl_assertions_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
   .early_read_in(early_read_in), .busy_out(busy_out), .timeout_err_out(timeout_err_out),
   .cs_n_out(cs_n_out), .rd_n_out(rd_n_out), .mode_out(mode_out), .strobe_pin_in(strobe_pin_in),
   .strobe_pin_out(strobe_pin_out), .strobe_pin_oe_n_out(strobe_pin_oe_n_out),
   .done_n_in(done_n_in));

// ==== bench/abc_dev_model.sv ====
// Behavioural model of the converter seen from its pins
`timescale 1ns/1ps
module abc_dev_model (
   // Clock and reset
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   // Bus pins
   input  wire logic       cs_n_in,
   input  wire logic       rd_n_in,
   input  wire logic       mode_in,
   input  wire logic       strobe_in,
   output logic            wait_low_out,
   output logic            done_n_out,
   output logic [7:0]      result_bus_out,
   // Test controls
   input  wire logic [7:0] sample_in,
   input  wire logic [7:0] conv_cyc_in,
   input  wire logic       hang_in
);
   logic       cs_q, rd_q, wr_q, busy_q, done_q;
   logic [7:0] cnt_q, latch_q;
   logic       en;
   assign en = !cs_n_in && !rd_n_in && (mode_in || done_q);
   assign result_bus_out = en ? latch_q : ~latch_q;
   assign wait_low_out = !mode_in && !cs_n_in && !rd_n_in && !done_q;
   assign done_n_out = !done_q;
   always_ff @(posedge clk_in or negedge rst_n_in)
      if (!rst_n_in)
      begin
         {cs_q, rd_q, wr_q, busy_q, done_q} <= 5'h1c;
         cnt_q <= 8'h00;
         latch_q <= 8'h00;
      end
      else
      begin
         {cs_q, rd_q, wr_q} <= {cs_n_in, rd_n_in, strobe_in};
         // Countdown first so that a new start below overrides a stale conversion
         if (busy_q && !hang_in)
         begin
            cnt_q <= cnt_q - 8'h01;
            if (cnt_q <= 8'h01)
               {busy_q, done_q} <= 2'h1;
         end
         if (!mode_in && !cs_n_in && !rd_n_in && (cs_q || rd_q))
         begin
            latch_q <= sample_in;
            {busy_q, done_q} <= 2'h2;
            cnt_q <= conv_cyc_in;
         end
         if (mode_in && !cs_n_in && !strobe_in && wr_q)
         begin
            latch_q <= sample_in;
            {busy_q, done_q} <= 2'h0;
         end
         if (mode_in && !cs_n_in && strobe_in && !wr_q)
         begin
            busy_q <= 1'b1;
            cnt_q <= conv_cyc_in;
         end
         if (mode_in && busy_q && !cs_n_in && !rd_n_in && rd_q)
            {busy_q, done_q} <= 2'h1;
         if ((cs_n_in && !cs_q) || (rd_n_in && !rd_q))
            done_q <= 1'b0;
      end
endmodule : abc_dev_model

// ==== bench/abc_ctrl_tb.sv ====
// Self-checking bench for the converter bus controller
`timescale 1ns/1ps
module abc_ctrl_tb;
   logic       clk_in = 0, rst_n_in = 0, start_in = 0, mode_in = 0, early_read_in = 0;
   logic       bipolar_in = 0, res_ready_in = 0, hang = 0;
   logic [7:0] sample = 8'h00, conv_cyc = 8'h08, bus, res_data_out;
   logic       busy_out, timeout_err_out, cs_n_out, rd_n_out, mode_out, strobe_pin_out;
   logic       oe_n, wait_low, done_n, res_valid_out;
   wire        pin = !oe_n ? strobe_pin_out : !wait_low;
   int         num_errors = 0, num_checks = 0, seed = 58947;
   logic [7:0] exp_q[$];
   always #25 clk_in = ~clk_in;
   abc_ctrl abc_ctrl_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .start_in(start_in),
      .mode_in(mode_in), .early_read_in(early_read_in), .bipolar_in(bipolar_in),
      .busy_out(busy_out), .timeout_err_out(timeout_err_out), .cs_n_out(cs_n_out),
      .rd_n_out(rd_n_out), .mode_out(mode_out), .strobe_pin_in(pin),
      .strobe_pin_out(strobe_pin_out), .strobe_pin_oe_n_out(oe_n), .done_n_in(done_n),
      .result_bus_in(bus), .res_valid_out(res_valid_out), .res_ready_in(res_ready_in),
      .res_data_out(res_data_out));
   abc_dev_model abc_dev_model_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .cs_n_in(cs_n_out),
      .rd_n_in(rd_n_out), .mode_in(mode_out), .strobe_in(pin), .wait_low_out(wait_low),
      .done_n_out(done_n), .result_bus_out(bus), .sample_in(sample), .conv_cyc_in(conv_cyc),
      .hang_in(hang));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      num_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, seen, exp);
      end
   endtask : check
   function automatic logic [7:0] exp_word(input logic [7:0] s, input logic b);
      return b ? s ^ 8'h80 : s;
   endfunction : exp_word
   task automatic convert(input logic m, e, b, input logic [7:0] s, c, input logic h, full);
      int n;
      @(posedge clk_in);
      {mode_in, early_read_in, bipolar_in, hang, start_in} <= {m, e, b, h, 1'b1};
      {sample, conv_cyc} <= {s, c};
      for (n = 0; n < 10 && busy_out !== 1'b1; n++)
      begin
         @(posedge clk_in);
         #1;
      end
      @(posedge clk_in);
      start_in <= 1'b0;
      #1;
      check(busy_out, !full, "start taken");
      for (n = 0; n < 200 && busy_out !== 1'b0; n++)
      begin
         @(posedge clk_in);
         #1;
      end
      check(busy_out, 1'b0, "conversion ended");
      if (!full)
         check(timeout_err_out, h, "timeout flag");
      if (!full && !h)
         exp_q.push_back(exp_word(s, b));
   endtask : convert
   task automatic drain();
      for (int n = 0; n < 400 && exp_q.size() > 0; n++)
      begin
         @(posedge clk_in);
         res_ready_in <= ($random(seed) % 2) != 0;
         #1;
         if (res_valid_out === 1'b1 && res_ready_in)
            check(res_data_out, exp_q.pop_front(), "result word");
      end
      @(posedge clk_in);
      res_ready_in <= 1'b0;
      check(8'(exp_q.size()), 8'h00, "words missing");
      repeat (3) @(posedge clk_in);
      #1;
      check(res_valid_out, 1'b0, "extra word");
   endtask : drain
   task automatic tally_and_finish();
      if (num_errors == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish
   initial
   begin
      repeat (3) @(posedge clk_in);
      rst_n_in <= 1'b1;
      // Fill the buffer with the sink stalled, last start refused
      for (int i = 0; i < 17; i++)
         convert(i[0], i[1], 1'b0, 8'($random(seed)), 8'(i + 3), 1'b0, i == 16);
      drain();
      convert(1'b0, 1'b0, 1'b0, 8'h5a, 8'h04, 1'b1, 1'b0);
      // Write-started conversion whose flag never comes
      convert(1'b1, 1'b0, 1'b0, 8'ha5, 8'h04, 1'b1, 1'b0);
      for (int i = 0; i < 44; i++)
      begin
         convert(1'($random(seed)), 1'($random(seed)), i[0],
                 i < 4 ? 8'h7f + 8'(i) : 8'($random(seed)),
                 8'h03 + 8'($random(seed) & 15), 1'b0, 1'b0);
         drain();
      end
      tally_and_finish();
   end
   initial
   begin
      repeat (20000) @(posedge clk_in);
      num_errors++;
      tally_and_finish();
   end
endmodule : abc_ctrl_tb
